// >>> rtl/rfcci_core.v
// What this block does
// R1: At most 128 bytes per cycle; fragment beyond
// R2: Per-protocol per-cycle size, default per protocol
// R3: Auto mode adopts first connecting protocol
// R4: Manual protocol skips detection, fixed forever
// R5: Other protocols get read access only
// R6: Five channel modes set per channel
// R7: Basic modes: single tag, no fragmentation
// R8: Full HF mode adds fragments and multitag
// R9: Full modes bound execution by timeout
// R10: Full HF continuous mode repeats, FIFO stores
// R11: Multidrop: 32 heads, one busy at once except in continuous broadcast
// R12: Each multidrop head reports tag presence
// R13: Continuous multidrop broadcasts, ring buffer logs
// R14: Presence sensing powers reader, repeats, FIFO
// R15: Decoder accepts the documented command set
// R16: Loop counter rerun within two cycles
// R17: Without loop counter, clear then set again
// R18: Success echoes command code in response
// R19: Unsupported command answered with error
`timescale 1ns/1ps
`include "rfcci_map.vh"
module rfcci_core #(
    parameter DEPTH = 64,
    parameter AW    = 6
) (
    input  wire        sys_clk,
    input  wire        srst,
    input  wire [1:0]  protoManual,
    input  wire [2:0]  connReq,
    input  wire        startupOver,
    input  wire [2:0]  cfgSizeA,
    input  wire [2:0]  cfgSizeB,
    input  wire [2:0]  cfgFragC,
    input  wire [2:0]  chMode,
    input  wire        multiTag,
    input  wire [15:0] timeoutCycles,
    input  wire        cmdValid,
    input  wire [7:0]  cmdCode,
    input  wire [7:0]  loopCnt,
    input  wire [15:0] cmdLen,
    input  wire [4:0]  cmdHeadAddr,
    input  wire        bufPop,
    input  wire        headDone,
    input  wire        headOk,
    input  wire        headDataValid,
    input  wire [7:0]  headData,
    input  wire [31:0] tagPresentPin,
    output reg  [1:0]  protoActive_q,
    output reg  [2:0]  writeGrant_q,
    output reg  [7:0]  cycleBytes_q,
    output reg  [8:0]  fragTotal_q,
    output reg         headReq_q,
    output reg  [4:0]  headAddr_q,
    output reg         headBcast_q,
    output reg         readerOn_q,
    output reg         rspBusy_q,
    output reg         rspDone_q,
    output reg  [7:0]  rspCode_q,
    output reg  [3:0]  rspErr_q,
    output reg  [7:0]  rspLoop_q,
    output reg  [7:0]  bufData_q,
    output reg         bufEmpty_q,
    output reg         bufOvf_q,
    output reg  [31:0] tagPresent_q
);

////////////////////////////////////////////////////////////////////////////
localparam [3:0] ST_IDLE  = 4'h1;
localparam [3:0] ST_ISSUE = 4'h2;
localparam [3:0] ST_WAIT  = 4'h4;
localparam [3:0] ST_CONT  = 4'h8;

function isFull;                                                // see R6
    input [2:0] m;
    begin
        isFull = (m == `RFCCI_M_HF_FULL) || (m == `RFCCI_M_UHF_FULL);
    end
endfunction

function isUhf;
    input [2:0] m;
    begin
        isUhf = (m == `RFCCI_M_UHF_BASIC) || (m == `RFCCI_M_UHF_FULL);
    end
endfunction

// Returns 1 when the mode may run the command
function cmdOk;
    input [2:0] m;
    input [7:0] c;
    input       mt;
    begin
        case (c)                                                // see R15
            `RFCCI_C_INVENT, `RFCCI_C_READ, `RFCCI_C_WRITE,
            `RFCCI_C_TAGINFO, `RFCCI_C_HEADPW, `RFCCI_C_RESET:
                cmdOk = 1'b1;
            `RFCCI_C_WRVERIFY, `RFCCI_C_TAGPW:
                cmdOk = !mt;
            `RFCCI_C_CONT:
                cmdOk = (m == `RFCCI_M_HF_FULL)
                     || (m == `RFCCI_M_HF_MDROP);
            `RFCCI_C_PRESENCE:
                cmdOk = (m == `RFCCI_M_UHF_FULL);
            `RFCCI_C_BUFREAD, `RFCCI_C_BUFDEL, `RFCCI_C_CONTSTOP:
                cmdOk = isFull(m) || (m == `RFCCI_M_HF_MDROP);
            `RFCCI_C_FAMILY, `RFCCI_C_FORMAT:
                cmdOk = !isUhf(m) && !mt;
            `RFCCI_C_ITEMCODE, `RFCCI_C_KILL,
            `RFCCI_C_BACKUP, `RFCCI_C_RESTORE:
                cmdOk = isUhf(m) && !mt;
            default:
                cmdOk = 1'b0;
        endcase
    end
endfunction

// Bytes per cycle for protocols A and B, fragment size for C; illegal codes fall back
function [7:0] sizeOf;
    input [1:0] p;
    input [2:0] a;
    input [2:0] b;
    input [2:0] f;
    begin
        case (p)
            `RFCCI_PROTO_A:
                sizeOf = (a > `RFCCI_SZ_128) ? 8'h10 : (8'h08 << a);
            `RFCCI_PROTO_B:
                sizeOf = (b == `RFCCI_SZ_16 || b == `RFCCI_SZ_64)
                       ? (8'h08 << b) : `RFCCI_MAX_BYTES;
            `RFCCI_PROTO_C:
                sizeOf = (f > `RFCCI_SZ_128) ? 8'h10 : (8'h08 << f);
            default:
                sizeOf = 8'h10;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Tag presence pins come from the heads' own timing
reg  [31:0] tagMeta_q;

always @(posedge sys_clk)
begin
    if (srst)
    begin
        tagMeta_q    <= 32'h0;
        tagPresent_q <= 32'h0;
    end
    else
    begin
        tagMeta_q    <= tagPresentPin;
        tagPresent_q <= tagMeta_q;      // see R12
    end
end

////////////////////////////////////////////////////////////////////////////
// Protocol binding; manual choice wins and is never released
always @(posedge sys_clk)
begin
    if (srst)
    begin
        protoActive_q <= `RFCCI_PROTO_NONE;
        writeGrant_q  <= 3'h0;
    end
    else
    begin
        if (protoActive_q == `RFCCI_PROTO_NONE)
        begin
            if (protoManual != `RFCCI_PROTO_NONE)
                protoActive_q <= protoManual;              // see R4
            else if (!startupOver && connReq[0])
                protoActive_q <= `RFCCI_PROTO_A;           // see R3
            else if (!startupOver && connReq[1])
                protoActive_q <= `RFCCI_PROTO_B;           // see R3
            else if (!startupOver && connReq[2])
                protoActive_q <= `RFCCI_PROTO_C;           // see R3
        end
        case (protoActive_q)
            `RFCCI_PROTO_A: writeGrant_q <= 3'h1;          // see R5
            `RFCCI_PROTO_B: writeGrant_q <= 3'h2;          // see R5
            `RFCCI_PROTO_C: writeGrant_q <= 3'h4;          // see R5
            default:        writeGrant_q <= 3'h0;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Command sequencer
reg  [3:0]  state_q;
reg         doneHeld_q;
reg  [7:0]  lastLoop_q;
reg  [15:0] tmo_q;
reg         ringMode_q;
reg         pushEn_q;
reg  [AW:0] cnt_q;
reg  [AW-1:0] wrPtr_q;
reg  [AW-1:0] rdPtr_q;
reg  [7:0]  mem_q [0:DEPTH-1];

wire [7:0]  szNow   = sizeOf(protoActive_q, cfgSizeA, cfgSizeB, cfgFragC);
wire [16:0] lenRnd  = {1'b0, cmdLen} + {9'h0, szNow} - 17'h1;
wire [2:0]  szLog   = szNow[7] ? 3'h7 : szNow[6] ? 3'h6 : szNow[5] ? 3'h5
                   : szNow[4] ? 3'h4 : 3'h3;
// Counts beyond nine bits wrap; the count port is only nine bits wide
wire [16:0] fragAll = lenRnd >> szLog;
// Re-run needs a new loop count, or the command cleared and set again
wire        fresh   = !doneHeld_q || (loopCnt != lastLoop_q);  // see R16
wire        trig    = cmdValid && (cmdCode != `RFCCI_C_IDLE) && fresh
                   && (protoActive_q != `RFCCI_PROTO_NONE);
wire        tooBig  = !isFull(chMode) && (cmdLen > 16'h0080);   // see R7
wire        badCmd  = !cmdOk(chMode, cmdCode, multiTag)        // see R19
                   || (multiTag && !isFull(chMode));            // see R8
wire        tmoHit  = isFull(chMode) && (tmo_q >= timeoutCycles)
                   && (timeoutCycles != 16'h0);                 // see R9
wire        isCont  = (cmdCode == `RFCCI_C_CONT)
                   || (cmdCode == `RFCCI_C_PRESENCE);
wire        full    = (cnt_q == DEPTH[AW:0]);
wire        push    = pushEn_q && headDataValid;
wire        pop     = bufPop && (cnt_q != {(AW+1){1'b0}});
wire        drop    = push && full && ringMode_q;
wire        wrOk    = push && (!full || ringMode_q);
wire        clrBuf  = (state_q == ST_ISSUE)
                   && (rspCode_q == `RFCCI_C_BUFDEL);

integer i;

always @(posedge sys_clk)
begin
    if (srst)
    begin
        state_q     <= ST_IDLE;
        doneHeld_q  <= 1'b0;
        lastLoop_q  <= 8'h0;
        tmo_q       <= 16'h0;
        headReq_q   <= 1'b0;
        headAddr_q  <= 5'h0;
        headBcast_q <= 1'b0;
        readerOn_q  <= 1'b0;
        rspBusy_q   <= 1'b0;
        rspDone_q   <= 1'b0;
        rspCode_q   <= `RFCCI_C_IDLE;
        rspErr_q    <= `RFCCI_E_NONE;
        rspLoop_q   <= 8'h0;
        cycleBytes_q <= 8'h10;
        fragTotal_q <= 9'h0;
        ringMode_q  <= 1'b0;
        pushEn_q    <= 1'b0;
    end
    else
    begin
        headReq_q    <= 1'b0;
        // Third protocol moves a fixed 128 bytes; szNow is its fragment
        cycleBytes_q <= (protoActive_q == `RFCCI_PROTO_C) ? `RFCCI_MAX_BYTES
                      : szNow;                                  // see R2
        if (!cmdValid)
        begin
            doneHeld_q <= 1'b0;                                 // see R17
            rspDone_q  <= 1'b0;
        end
        case (state_q)
            ST_IDLE:
                if (trig)
                begin
                    lastLoop_q <= loopCnt;
                    rspCode_q  <= cmdCode;
                    rspBusy_q  <= 1'b1;
                    rspDone_q  <= 1'b0;
                    tmo_q      <= 16'h0;
                    // Whole fragments of at most 128 bytes each
                    fragTotal_q <= fragAll[8:0];                // see R1
                    if (badCmd || tooBig)
                    begin
                        rspErr_q   <= badCmd ? `RFCCI_E_UNSUP
                                             : `RFCCI_E_SIZE;
                        rspBusy_q  <= 1'b0;
                        rspDone_q  <= 1'b1;
                        doneHeld_q <= 1'b1;
                        rspLoop_q  <= loopCnt;
                        rspCode_q  <= `RFCCI_C_IDLE;            // see R18
                    end
                    else
                    begin
                        rspErr_q <= `RFCCI_E_NONE;
                        state_q  <= ST_ISSUE;
                    end
                end
            ST_ISSUE:
            begin
                headReq_q   <= 1'b1;                            // see R16
                // Only the addressed head runs unless broadcasting
                headAddr_q  <= cmdHeadAddr;                     // see R11
                headBcast_q <= isCont
                            && (chMode == `RFCCI_M_HF_MDROP);   // see R13
                readerOn_q  <= isUhf(chMode);                   // see R14
                ringMode_q  <= (chMode == `RFCCI_M_HF_MDROP);   // see R13
                pushEn_q    <= isCont;                          // see R10
                state_q     <= isCont ? ST_CONT : ST_WAIT;
            end
            ST_WAIT:
            begin
                tmo_q <= tmo_q + 16'h1;
                if (headDone || tmoHit)
                begin
                    rspErr_q   <= tmoHit && !headDone ? `RFCCI_E_TIMEOUT
                                : headOk ? `RFCCI_E_NONE : `RFCCI_E_HEAD;
                    rspCode_q  <= (headDone && headOk) ? rspCode_q
                                : `RFCCI_C_IDLE;                // see R18
                    rspBusy_q  <= 1'b0;
                    rspDone_q  <= 1'b1;
                    rspLoop_q  <= lastLoop_q;
                    doneHeld_q <= 1'b1;
                    readerOn_q <= 1'b0;                         // see R14
                    state_q    <= ST_IDLE;
                end
            end
            ST_CONT:
            begin
                // The head runs once per request; reissue after each result
                if (headDone)
                    headReq_q <= 1'b1;                          // see R10
                if (!rspDone_q)
                begin
                    rspDone_q  <= 1'b1;
                    doneHeld_q <= 1'b1;
                    rspLoop_q  <= lastLoop_q;
                end
                if (cmdValid && cmdCode == `RFCCI_C_CONTSTOP)
                begin
                    pushEn_q    <= 1'b0;
                    headBcast_q <= 1'b0;
                    readerOn_q  <= 1'b0;
                    rspBusy_q   <= 1'b0;
                    rspCode_q   <= `RFCCI_C_CONTSTOP;
                    doneHeld_q  <= 1'b1;
                    state_q     <= ST_IDLE;
                end
            end
            default:
                state_q <= ST_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Result store: FIFO refuses when full, ring drops the oldest entry
always @(posedge sys_clk)
begin
    if (srst || clrBuf)
    begin
        wrPtr_q    <= {AW{1'b0}};
        rdPtr_q    <= {AW{1'b0}};
        cnt_q      <= {(AW+1){1'b0}};
        bufData_q  <= 8'h0;
        bufEmpty_q <= 1'b1;
        bufOvf_q   <= 1'b0;
    end
    else
    begin
        if (wrOk)
            wrPtr_q <= wrPtr_q + {{(AW-1){1'b0}}, 1'b1};        // see R10
        if (pop || drop)
            rdPtr_q <= rdPtr_q + {{(AW-1){1'b0}}, 1'b1};        // see R13
        if (pop)
            bufData_q <= mem_q[rdPtr_q];                        // see R14
        if (wrOk && !(pop || drop))
            cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
        else if (!wrOk && pop)
            cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
        if (push && full && !ringMode_q)
            bufOvf_q <= 1'b1;
        bufEmpty_q <= (cnt_q == {(AW+1){1'b0}}) && !wrOk
                   || (cnt_q == {{AW{1'b0}}, 1'b1} && pop && !wrOk);
    end
end

// Storage has no reset; pointers define what is valid
always @(posedge sys_clk)
begin
    for (i = 0; i < DEPTH; i = i + 1)
        if (wrOk && wrPtr_q == i[AW-1:0])
            mem_q[i] <= headData;
end

endmodule

// >>> rtl/rfcci_map.vh
`ifndef RFCCI_MAP_VH
`define RFCCI_MAP_VH
// Fieldbus protocols, 0 means none or automatic detection
`define RFCCI_PROTO_NONE  2'h0
`define RFCCI_PROTO_A     2'h1
`define RFCCI_PROTO_B     2'h2
`define RFCCI_PROTO_C     2'h3
// Per-cycle size codes, bytes = 8 << code
`define RFCCI_SZ_8        3'h0
`define RFCCI_SZ_16       3'h1
`define RFCCI_SZ_32       3'h2
`define RFCCI_SZ_64       3'h3
`define RFCCI_SZ_128      3'h4
`define RFCCI_MAX_BYTES   8'h80
// Channel data interface modes
`define RFCCI_M_HF_BASIC  3'h0
`define RFCCI_M_HF_FULL   3'h1
`define RFCCI_M_HF_MDROP  3'h2
`define RFCCI_M_UHF_BASIC 3'h3
`define RFCCI_M_UHF_FULL  3'h4
// Command codes
`define RFCCI_C_IDLE      8'h00
`define RFCCI_C_INVENT    8'h01
`define RFCCI_C_READ      8'h02
`define RFCCI_C_WRITE     8'h03
`define RFCCI_C_WRVERIFY  8'h04
`define RFCCI_C_TAGINFO   8'h05
`define RFCCI_C_CONT      8'h10
`define RFCCI_C_BUFREAD   8'h11
`define RFCCI_C_CONTSTOP  8'h12
`define RFCCI_C_PRESENCE  8'h13
`define RFCCI_C_BUFDEL    8'h14
`define RFCCI_C_HEADPW    8'h20
`define RFCCI_C_TAGPW     8'h21
`define RFCCI_C_FAMILY    8'h30
`define RFCCI_C_FORMAT    8'h31
`define RFCCI_C_ITEMCODE  8'h32
`define RFCCI_C_KILL      8'h33
`define RFCCI_C_BACKUP    8'h40
`define RFCCI_C_RESTORE   8'h41
`define RFCCI_C_RESET     8'h7F
// Response error codes
`define RFCCI_E_NONE      4'h0
`define RFCCI_E_UNSUP     4'h1
`define RFCCI_E_SIZE      4'h2
`define RFCCI_E_TIMEOUT   4'h3
`define RFCCI_E_HEAD      4'h4
`endif

// >>> tb/rfcci_core_asserts.sv
`timescale 1ns/1ps
`include "rfcci_map.vh"
module rfcci_core_asserts (
    input wire        sys_clk,
    input wire        srst,
    input wire [2:0]  chMode,
    input wire        multiTag,
    input wire        cmdValid,
    input wire [7:0]  cmdCode,
    input wire [7:0]  loopCnt,
    input wire [15:0] cmdLen,
    input wire        headDone,
    input wire        headOk,
    input wire [31:0] tagPresentPin,
    input wire [1:0]  protoActive_q,
    input wire [2:0]  writeGrant_q,
    input wire [7:0]  cycleBytes_q,
    input wire        headReq_q,
    input wire        readerOn_q,
    input wire        rspBusy_q,
    input wire        rspDone_q,
    input wire [7:0]  rspCode_q,
    input wire [3:0]  rspErr_q,
    input wire [7:0]  rspLoop_q,
    input wire [31:0] tagPresent_q
);
    // Idle and bound, so a fresh command must be taken
    wire canTake = !rspBusy_q && !rspDone_q && protoActive_q != 2'h0;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
////////////////////////////////////////////////////////////
    AST_GRANT: assert property ($rose(protoActive_q != 2'h0)
        |=> writeGrant_q == (3'h1 << (protoActive_q - 2'h1)))
        else $error("write grant wrong");
    AST_PROTO_HOLD: assert property (protoActive_q != 2'h0
        |=> $stable(protoActive_q)) else $error("protocol changed");
    AST_SIZE_C: assert property (protoActive_q == 2'h3 [*3]
        |-> cycleBytes_q == 8'h80) else $error("size not 128");
    AST_REQ_PULSE: assert property (headReq_q |=> !headReq_q)
        else $error("head request too long");
    AST_START: assert property ($rose(rspBusy_q) |=> headReq_q)
        else $error("head not started");
    AST_ECHO: assert property (rspBusy_q && headDone && headOk
        && cmdCode < `RFCCI_C_CONT |=> rspDone_q && rspErr_q == 4'h0
        && rspCode_q == $past(cmdCode)) else $error("code not echoed");
    AST_SIZE_ERR: assert property (canTake && cmdValid
        && cmdCode == `RFCCI_C_READ && chMode == `RFCCI_M_HF_BASIC
        && !multiTag && cmdLen > 16'h0080 |=> rspDone_q
        && rspErr_q == `RFCCI_E_SIZE) else $error("size error missing");
    AST_UNSUP: assert property (canTake && cmdValid && multiTag
        && cmdCode == `RFCCI_C_INVENT && chMode == `RFCCI_M_HF_BASIC
        |=> rspDone_q && rspErr_q == `RFCCI_E_UNSUP)
        else $error("unsupported not refused");
    AST_LOOP: assert property (rspDone_q && !rspBusy_q
        && rspErr_q == 4'h0 && rspCode_q < `RFCCI_C_CONT && cmdValid
        && cmdCode == rspCode_q && loopCnt != rspLoop_q |=> rspBusy_q)
        else $error("loop rerun not taken");
    AST_TAG_SYNC: assert property ($stable(tagPresentPin) [*4]
        |-> tagPresent_q == tagPresentPin) else $error("tag sync wrong");
    AST_READER: assert property (readerOn_q
        |-> chMode == `RFCCI_M_UHF_FULL) else $error("reader on");
    cover property (rspDone_q && rspErr_q == `RFCCI_E_TIMEOUT);
    cover property (headReq_q && cmdCode == `RFCCI_C_CONT);
    cover property ($rose(rspBusy_q) && loopCnt != 8'h00);
endmodule

// >>> tb/rfcci_head_model.sv
`timescale 1ns/1ps
module rfcci_head_model (
    input  wire        sys_clk,
    input  wire        srst,
    input  wire        headReq,
    input  wire [7:0]  delay,
    output reg         headDone,
    output reg         headOk,
    output reg         headDataValid,
    output reg  [7:0]  headData = 8'h5A,
    output wire [31:0] tagPresentPin
);
    reg [7:0] cnt;
    reg [7:0] seq;
////////////////////////////////////////////////////////////
    // Head 0 flags a tag on odd results
    assign tagPresentPin = {31'h0, seq[0]};
    // Zero delay is a head that never answers; data toggles when idle
    always @(posedge sys_clk)
    begin
        headDone <= 1'b0;
        headOk <= 1'b0;
        headDataValid <= 1'b0;
        headData <= ~headData;
        if (srst)
        begin
            cnt <= 8'h00;
            seq <= 8'hA0;
        end
        else if (headReq && delay != 8'h00)
            cnt <= delay;
        else if (cnt != 8'h00)
        begin
            cnt <= cnt - 8'h01;
            if (cnt == 8'h01)
            begin
                headDone <= 1'b1; // One job at a time
                headOk <= 1'b1;
                headDataValid <= 1'b1;
                headData <= seq;
                seq <= seq + 8'h01;
            end
        end
    end
endmodule

// >>> tb/test_rfid_channel_command_interface.sv
`timescale 1ns/1ps
`include "rfcci_map.vh"
module test_rfid_channel_command_interface;
    reg         sys_clk = 1'b0;
    reg         srst = 1'b1;
    reg  [1:0]  protoManual = 2'h0;
    reg  [2:0]  connReq = 3'h0;
    reg         startupOver = 1'b0;
    reg  [2:0]  chMode = `RFCCI_M_HF_FULL;
    reg         multiTag = 1'b0;
    reg  [15:0] timeoutCycles = 16'h0000;
    reg         cmdValid = 1'b0;
    reg  [7:0]  cmdCode = 8'h00;
    reg  [7:0]  loopCnt = 8'h00;
    reg  [15:0] cmdLen = 16'h00C8;
    reg         bufPop = 1'b0;
    reg  [7:0]  delay = 8'h03;
    reg  [4:0]  headSel = 5'h03;
    wire [4:0]  headAddr_q;
    wire        headBcast_q;
    wire [1:0]  protoActive_q;
    wire [2:0]  writeGrant_q;
    wire [7:0]  cycleBytes_q;
    wire [8:0]  fragTotal_q;
    wire        headReq_q;
    wire        rspBusy_q;
    wire        rspDone_q;
    wire [7:0]  rspCode_q;
    wire [3:0]  rspErr_q;
    wire [7:0]  rspLoop_q;
    wire [7:0]  bufData_q;
    wire        bufEmpty_q;
    wire        bufOvf_q;
    wire        headDone;
    wire        headOk;
    wire        headDataValid;
    wire [7:0]  headData;
    wire [31:0] tagPresentPin;
    integer     num_errors;
    integer     samples_checked;
    integer     i;
    // Eight HF codes, then four UHF codes, lowest byte first
    localparam [95:0] CODES = {8'h41, 8'h40, 8'h33, 8'h32, 8'h31, 8'h30,
        8'h21, 8'h20, 8'h05, 8'h04, 8'h03, 8'h01};
////////////////////////////////////////////////////////////
    rfcci_core #(.DEPTH(4), .AW(2)) u_rfcci_core (
        .sys_clk(sys_clk), .srst(srst), .protoManual(protoManual),
        .connReq(connReq), .startupOver(startupOver),
        .cfgSizeA(`RFCCI_SZ_16), .cfgSizeB(`RFCCI_SZ_64),
        .cfgFragC(`RFCCI_SZ_16), .chMode(chMode), .multiTag(multiTag),
        .timeoutCycles(timeoutCycles), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .loopCnt(loopCnt), .cmdLen(cmdLen),
        .cmdHeadAddr(headSel), .bufPop(bufPop), .headDone(headDone),
        .headOk(headOk), .headDataValid(headDataValid),
        .headData(headData), .tagPresentPin(tagPresentPin),
        .protoActive_q(protoActive_q), .writeGrant_q(writeGrant_q),
        .cycleBytes_q(cycleBytes_q), .fragTotal_q(fragTotal_q),
        .headReq_q(headReq_q), .headAddr_q(headAddr_q),
        .headBcast_q(headBcast_q), .readerOn_q(), .rspBusy_q(rspBusy_q),
        .rspDone_q(rspDone_q), .rspCode_q(rspCode_q), .rspErr_q(rspErr_q),
        .rspLoop_q(rspLoop_q), .bufData_q(bufData_q),
        .bufEmpty_q(bufEmpty_q), .bufOvf_q(bufOvf_q), .tagPresent_q());
    rfcci_head_model u_rfcci_head_model (.sys_clk(sys_clk), .srst(srst),
        .headReq(headReq_q), .delay(delay), .headDone(headDone),
        .headOk(headOk), .headDataValid(headDataValid),
        .headData(headData), .tagPresentPin(tagPresentPin));
    always #5 sys_clk = ~sys_clk;
    task step;
    begin
        @(posedge sys_clk);
        #1;
    end
    endtask
    task chk(input [95:0] nm, input [31:0] exp, input [31:0] got);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("wrong value %0s expected %h seen %h", nm, exp, got);
        end
    end
    endtask
    task tally_and_finish;
    begin
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    task wait_done;
        integer n;
    begin
        for (n = 0; n < 300 && rspDone_q !== 1'b1; n = n + 1)
            step;
        if (n == 300)
        begin
            chk("done", 1, 0);
            tally_and_finish;
        end
    end
    endtask
    task run_cmd(input [7:0] code, input [3:0] err);
    begin
        cmdValid = 1'b0; // Drop first so a repeat is taken
        step;
        cmdCode = code;
        cmdValid = 1'b1;
        step;
        wait_done;
        chk("err", err, rspErr_q);
        chk("code", err == 4'h0 ? code : 8'h00, rspCode_q);
    end
    endtask
    initial
    begin
        num_errors = 0;
        samples_checked = 0;
        repeat (16) step;
        srst = 1'b0;
        connReq = 3'h2;
        repeat (3) step;
        chk("proto", 2, protoActive_q);
        chk("grant", 3'h2, writeGrant_q);
        chk("bytes", 8'h40, cycleBytes_q);
        startupOver = 1'b1;
        connReq = 3'h1;
        repeat (3) step;
        chk("proto", 2, protoActive_q);
        run_cmd(`RFCCI_C_READ, `RFCCI_E_NONE);
        chk("frags", 9'h004, fragTotal_q);
        loopCnt = 8'h01;
        repeat (2) step;
        chk("busy", 1, rspBusy_q);
        wait_done;
        chk("loop", 8'h01, rspLoop_q);
        for (i = 0; i < 12; i = i + 1)
        begin
            chMode = i < 8 ? `RFCCI_M_HF_FULL : `RFCCI_M_UHF_FULL;
            run_cmd(CODES[8*i +: 8], `RFCCI_E_NONE);
        end
        chMode = `RFCCI_M_HF_BASIC;
        run_cmd(`RFCCI_C_READ, `RFCCI_E_SIZE);
        cmdLen = 16'h0080;
        run_cmd(`RFCCI_C_READ, `RFCCI_E_NONE);
        multiTag = 1'b1;
        run_cmd(`RFCCI_C_INVENT, `RFCCI_E_UNSUP);
        multiTag = 1'b0;
        chMode = `RFCCI_M_HF_FULL;
        timeoutCycles = 16'h0014;
        delay = 8'h00;
        run_cmd(`RFCCI_C_READ, `RFCCI_E_TIMEOUT);
        // Manual binding must apply after reset; startupOver still blocks the pending request
        cmdValid = 1'b0;
        delay = 8'h03;
        protoManual = 2'h3;
        srst = 1'b1;
        repeat (2) step;
        srst = 1'b0;
        repeat (3) step;
        chk("proto", 3, protoActive_q);
        chk("bytes", 8'h80, cycleBytes_q);
        run_cmd(`RFCCI_C_CONT, `RFCCI_E_NONE);
        repeat (60) step;
        chk("ovf", 1, bufOvf_q);
        cmdCode = `RFCCI_C_CONTSTOP;
        repeat (4) step;
        cmdValid = 1'b0;
        for (i = 0; i < 4; i = i + 1)
        begin
            bufPop = 1'b1;
            step;
            bufPop = 1'b0;
            step;
            chk("fifo", 8'hA0 + i, bufData_q);
        end
        chk("empty", 1, bufEmpty_q);
        // Buffer delete must also clear the sticky overflow
        run_cmd(`RFCCI_C_BUFDEL, `RFCCI_E_NONE);
        chk("ovf", 0, bufOvf_q);
        // Multidrop continuous run: broadcast, ring never overflows
        chMode = `RFCCI_M_HF_MDROP;
        headSel = 5'h11;
        run_cmd(`RFCCI_C_CONT, `RFCCI_E_NONE);
        repeat (60) step;
        chk("bcast", 1, headBcast_q);
        chk("addr", 5'h11, headAddr_q);
        chk("ring", 0, bufOvf_q);
        chk("held", 0, bufEmpty_q);
        cmdCode = `RFCCI_C_CONTSTOP;
        repeat (2) step;
        chk("stop", 0, headBcast_q);
        chk("code", `RFCCI_C_CONTSTOP, rspCode_q);
        tally_and_finish;
    end
endmodule
bind rfcci_core rfcci_core_asserts u_rfcci_core_asserts (
    .sys_clk(sys_clk), .srst(srst), .chMode(chMode), .multiTag(multiTag),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .loopCnt(loopCnt),
    .cmdLen(cmdLen), .headDone(headDone), .headOk(headOk),
    .tagPresentPin(tagPresentPin), .protoActive_q(protoActive_q),
    .writeGrant_q(writeGrant_q), .cycleBytes_q(cycleBytes_q),
    .headReq_q(headReq_q), .readerOn_q(readerOn_q), .rspBusy_q(rspBusy_q),
    .rspDone_q(rspDone_q), .rspCode_q(rspCode_q), .rspErr_q(rspErr_q),
    .rspLoop_q(rspLoop_q), .tagPresent_q(tagPresent_q));
